// [rtl/hbms_top.sv]
// Mode sequencer for a boost plus half-bridge driver controller.
// Inputs are comparator decisions; outputs feed external gate drivers.
`timescale 1ns/10ps
`include "hbms_consts.svh"
// Behaviour
// - In supply lockout both drives stay low and the oscillator is stopped.
// - Leave lockout when supply above start threshold and dim input low.
// - High-side toggles only once floating supply passes its start threshold.
// - Bootstrap switch is on during every low-side on-time.
// - Drives alternate at half duty with 1.6 us deadtime between them.
// - Run starts at minimum frequency; raising it is external.
// - Bridge over-current only counts while the low-side drive is on.
// - Count over-current low-side cycles; a count of 65 enters fault mode.
// - Clean low-side cycles count down by one, stopping at zero.
// - Dim input high in run enters dim mode with all gates low.
// - Fault forces gates low and discharges compensation; dim keeps it.
// - Dim input low again leaves dim mode and resumes switching.
// - Boost gate waits for zero inductor current before turning on.
// - Zero-current rising edge starts off-time; falling edge turns gate on.
// - Watchdog forces the boost gate on after about 400 us.
// - Boost over-current turns gate off until next turn-on event.
// - Over-voltage holds boost low; release forces one watchdog pulse.
module hbms_top
    import hbms_pkg::*;
#(
    parameter int unsigned DEAD_CYC   = `HBMS_DEAD_CYC,
    parameter int unsigned HALF_CYC   = `HBMS_HALF_PERIOD,
    parameter int unsigned FAULT_EVTS = `HBMS_FAULT_EVENTS,
    parameter int unsigned WDOG_CYC   = `HBMS_WDOG_CYC,
    parameter int unsigned BOOST_ON   = `HBMS_BOOST_ON_CYC
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_nrst,
    // Comparator decisions
    input  wire logic i_supply_above_start,
    input  wire logic i_high_side_above_start,
    input  wire logic i_dim_above_high,
    input  wire logic i_dim_below_low,
    input  wire logic i_bridge_overcurrent,
    input  wire logic i_zero_current_detect,
    input  wire logic i_boost_current_sense,
    input  wire logic i_bus_overvoltage,
    // Drives and controls
    output logic      o_low_side_drive,
    output logic      o_high_side_drive,
    output logic      o_boost_gate_drive,
    output logic      o_bootstrap_on,
    output logic      o_comp_discharge,
    output logic      o_osc_run,
    output logic      o_fault
);
    import hbms_pkg::*;

    localparam int PW = $clog2(HALF_CYC + 1);
    localparam int FW = $clog2(FAULT_EVTS + 1);
    localparam int NS = 8;

    if (DEAD_CYC < 1 || HALF_CYC <= DEAD_CYC || FAULT_EVTS < 1) begin : g_bad_timing
        $error("hbms_top: bad timing parameters");
    end

    // Two-stage synchronisers for every comparator
    logic [NS-1:0] raw;
    logic [NS-1:0] sync1_r;
    logic [NS-1:0] sync2_r;
    assign raw = {i_supply_above_start, i_high_side_above_start, i_dim_above_high, i_dim_below_low,
                  i_bridge_overcurrent, i_zero_current_detect, i_boost_current_sense, i_bus_overvoltage};

    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_sync
            always_ff @(posedge i_sys_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    sync1_r[g] <= 1'b0;
                    sync2_r[g] <= 1'b0;
                end else begin
                    sync1_r[g] <= raw[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    wire s_supply = sync2_r[7];
    wire s_hs_ok  = sync2_r[6];
    wire s_dim_hi = sync2_r[5];
    wire s_dim_lo = sync2_r[4];
    wire s_bocp   = sync2_r[3];
    wire s_zcd    = sync2_r[2];
    wire s_pocp   = sync2_r[1];
    wire s_ovp    = sync2_r[0];

    hbms_mode_t    mode_r;
    hbms_mode_t    mode_nxt;
    hbms_phase_t   phase_r;
    hbms_phase_t   phase_nxt;
    logic [PW-1:0] pcnt_r;
    logic [PW-1:0] pcnt_nxt;
    logic [FW-1:0] fcnt_r;
    logic [FW-1:0] fcnt_nxt;
    logic          ev_seen_r;
    logic          ev_seen_nxt;
    logic          hs_en_r;
    logic          lo_r;
    logic          ho_r;
    logic          boot_r;
    logic          compdis_r;
    logic          osc_r;
    logic          fault_r;
    logic          boost_gate;

    wire running   = (mode_r == HBMS_RUN);
    wire fault_hit = (fcnt_nxt >= FW'(FAULT_EVTS));
    wire phase_end = (pcnt_r >= PW'((phase_r == HBMS_LS_ON || phase_r == HBMS_HS_ON)
                                    ? HALF_CYC - DEAD_CYC - 1 : DEAD_CYC - 1));
    wire ls_end    = running && phase_end && (phase_r == HBMS_LS_ON);
    wire ls_event  = s_bocp & lo_r;
    // First run cycle: low side not up yet, hold the count so the first pulse is full length
    wire run_entry = running && (phase_r == HBMS_LS_ON) && !lo_r;

    // Mode sequencing
    always_comb begin
        mode_nxt = mode_r;
        if (!s_supply) begin
            mode_nxt = HBMS_LOCKOUT;
        end else begin
            case (mode_r)
                HBMS_LOCKOUT: if (s_dim_lo && !s_dim_hi) mode_nxt = HBMS_RUN;
                HBMS_RUN: begin
                    if (ls_end && fault_hit) begin
                        mode_nxt = HBMS_FAULT;
                    end else if (s_dim_hi) begin
                        mode_nxt = HBMS_DIM;
                    end
                end
                HBMS_DIM:   if (s_dim_lo) mode_nxt = HBMS_RUN;
                HBMS_FAULT: mode_nxt = HBMS_FAULT;
                default:    mode_nxt = HBMS_LOCKOUT;
            endcase
        end
    end

    // Oscillator phase, restarted at the low-side phase with fixed minimum period
    always_comb begin
        phase_nxt = phase_r;
        pcnt_nxt  = pcnt_r + PW'(1);
        if (!running || mode_nxt != HBMS_RUN) begin
            phase_nxt = HBMS_LS_ON;
            pcnt_nxt  = '0;
        end else if (run_entry) begin
            pcnt_nxt  = '0;
        end else if (phase_end) begin
            pcnt_nxt = '0;
            case (phase_r)
                HBMS_LS_ON:  phase_nxt = HBMS_DEAD_A;
                HBMS_DEAD_A: phase_nxt = HBMS_HS_ON;
                HBMS_HS_ON:  phase_nxt = HBMS_DEAD_B;
                HBMS_DEAD_B: phase_nxt = HBMS_LS_ON;
                default:     phase_nxt = HBMS_LS_ON;
            endcase
        end
    end

    // Up/down fault counter, one step per low-side cycle
    always_comb begin
        fcnt_nxt    = fcnt_r;
        ev_seen_nxt = ev_seen_r | ls_event;
        if (mode_r == HBMS_LOCKOUT) begin
            fcnt_nxt    = '0;
            ev_seen_nxt = 1'b0;
        end else if (ls_end) begin
            ev_seen_nxt = 1'b0;
            if (ev_seen_r || ls_event) begin
                fcnt_nxt = fcnt_r + FW'(1);
            end else if (fcnt_r != '0) begin
                fcnt_nxt = fcnt_r - FW'(1);
            end
        end
    end

    wire lo_nxt = running && (mode_nxt == HBMS_RUN) && (phase_nxt == HBMS_LS_ON);
    wire ho_nxt = running && (mode_nxt == HBMS_RUN) && (phase_nxt == HBMS_HS_ON) && hs_en_r;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_r    <= HBMS_LOCKOUT;
            phase_r   <= HBMS_LS_ON;
            pcnt_r    <= '0;
            fcnt_r    <= '0;
            ev_seen_r <= 1'b0;
            hs_en_r   <= 1'b0;
            lo_r      <= 1'b0;
            ho_r      <= 1'b0;
            boot_r    <= 1'b0;
            compdis_r <= 1'b0;
            osc_r     <= 1'b0;
            fault_r   <= 1'b0;
        end else begin
            mode_r    <= mode_nxt;
            phase_r   <= phase_nxt;
            pcnt_r    <= pcnt_nxt;
            fcnt_r    <= fcnt_nxt;
            ev_seen_r <= ev_seen_nxt;
            hs_en_r   <= (mode_r != HBMS_LOCKOUT) && (hs_en_r || s_hs_ok);
            lo_r      <= lo_nxt;
            ho_r      <= ho_nxt;
            boot_r    <= lo_nxt;
            compdis_r <= (mode_nxt == HBMS_FAULT) || (mode_nxt == HBMS_LOCKOUT);
            osc_r     <= (mode_nxt == HBMS_RUN);
            fault_r   <= (mode_nxt == HBMS_FAULT);
        end
    end

    hbms_boost #(
        .WDOG_CYC (WDOG_CYC),
        .ON_CYC   (BOOST_ON)
    ) u_boost (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_enable  (running && mode_nxt == HBMS_RUN),
        .i_zcd     (s_zcd),
        .i_ocp     (s_pocp),
        .i_ovp     (s_ovp),
        .o_gate    (boost_gate)
    );

    assign o_low_side_drive   = lo_r;
    assign o_high_side_drive  = ho_r;
    assign o_boost_gate_drive = boost_gate;
    assign o_bootstrap_on     = boot_r;
    assign o_comp_discharge   = compdis_r;
    assign o_osc_run          = osc_r;
    assign o_fault            = fault_r;

    a_lockout_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        mode_r == HBMS_LOCKOUT |-> !lo_r && !ho_r && !osc_r)
        else $error("drive active in lockout");
    a_no_overlap: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        $fell(lo_r) |-> !ho_r [*8])
        else $error("deadtime violated after low-side off");
    a_hs_gated: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !hs_en_r |=> !ho_r)
        else $error("high side toggled before floating supply ready");
    a_boot_follows: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        boot_r == lo_r)
        else $error("bootstrap switch not tied to low-side on-time");
    a_fault_latched: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        mode_r == HBMS_FAULT && s_supply |=> mode_r == HBMS_FAULT)
        else $error("fault mode left without lockout");
    a_fault_gates_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        mode_r == HBMS_FAULT |=> !lo_r && !ho_r && compdis_r)
        else $error("fault mode outputs wrong");
    a_dim_keeps_comp: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        mode_r == HBMS_DIM && mode_nxt == HBMS_DIM |=> !lo_r && !ho_r && !compdis_r && !boost_gate)
        else $error("dim mode outputs wrong");
    a_count_down: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        ls_end && !ev_seen_r && !ls_event && fcnt_r != '0 && mode_r != HBMS_LOCKOUT
        |=> fcnt_r == $past(fcnt_r) - FW'(1))
        else $error("fault counter did not count down");
endmodule : hbms_top

// [rtl/hbms_consts.svh]
// Timing counts and limits of the half-bridge mode sequencer.
// Assumes the 40 MHz system clock.
`ifndef HBMS_CONSTS_SVH
`define HBMS_CONSTS_SVH
`define HBMS_CLK_MHZ        40
`define HBMS_DEADTIME_NS    1600
`define HBMS_DEAD_CYC       ((`HBMS_DEADTIME_NS * `HBMS_CLK_MHZ) / 1000)
`define HBMS_WDOG_US        400
`define HBMS_WDOG_CYC       (`HBMS_WDOG_US * `HBMS_CLK_MHZ)
`define HBMS_FAULT_EVENTS   65
`define HBMS_HALF_PERIOD    449
`define HBMS_BOOST_ON_CYC   200
`endif

// [rtl/hbms_pkg.sv]
// Types of the half-bridge mode sequencer.
// Used by the sequencer and its bench; the boost stage does not import it.
package hbms_pkg;
    typedef enum logic [2:0] {
        HBMS_LOCKOUT,
        HBMS_RUN,
        HBMS_DIM,
        HBMS_FAULT
    } hbms_mode_t;
    typedef enum logic [1:0] {
        HBMS_LS_ON,
        HBMS_DEAD_A,
        HBMS_HS_ON,
        HBMS_DEAD_B
    } hbms_phase_t;
endpackage : hbms_pkg

// [rtl/hbms_boost.sv]
// Critical-conduction boost gate stage.
// Inputs already synchronised; enable is low outside run mode.
`timescale 1ns/10ps
`include "hbms_consts.svh"
module hbms_boost #(
    parameter int unsigned WDOG_CYC = `HBMS_WDOG_CYC,
    parameter int unsigned ON_CYC   = `HBMS_BOOST_ON_CYC
) (
    input  wire logic i_sys_clk,
    input  wire logic i_nrst,
    input  wire logic i_enable,
    input  wire logic i_zcd,
    input  wire logic i_ocp,
    input  wire logic i_ovp,
    output logic      o_gate
);
    localparam int CW = $clog2(WDOG_CYC + 1);
    if (WDOG_CYC < 2 || ON_CYC < 1 || ON_CYC >= WDOG_CYC) begin : g_bad_timing
        $error("hbms_boost: bad timing parameters");
    end

    logic          gate_r;
    logic          zcd_d_r;
    logic          ovp_d_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          gate_nxt;

    wire zcd_fall = zcd_d_r & ~i_zcd;
    wire wdog_hit = (cnt_r >= CW'(WDOG_CYC - 1));
    wire ovp_clr  = ovp_d_r & ~i_ovp;
    wire on_done  = (cnt_r >= CW'(ON_CYC - 1));
    // Turn-on: zero current, watchdog, or one forced pulse after over-voltage
    wire turn_on  = ~gate_r & (zcd_fall | wdog_hit | ovp_clr);
    // Turn-off: fixed on-time or immediate over-current
    wire turn_off = gate_r & (on_done | i_ocp);

    always_comb begin
        gate_nxt = gate_r;
        cnt_nxt  = cnt_r + CW'(1);
        if (!i_enable || i_ovp) begin
            gate_nxt = 1'b0;
            cnt_nxt  = '0;
        end else if (turn_on) begin
            gate_nxt = 1'b1;
            cnt_nxt  = '0;
        end else if (turn_off) begin
            gate_nxt = 1'b0;
            cnt_nxt  = '0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            gate_r  <= 1'b0;
            zcd_d_r <= 1'b0;
            ovp_d_r <= 1'b0;
            cnt_r   <= '0;
        end else begin
            gate_r  <= gate_nxt;
            zcd_d_r <= i_zcd;
            ovp_d_r <= i_ovp;
            cnt_r   <= cnt_nxt;
        end
    end

    assign o_gate = gate_r;

    a_ocp_gate_off: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        gate_r && i_ocp |=> !gate_r)
        else $error("boost gate stayed on under over-current");
    a_ovp_gate_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_ovp |=> !gate_r)
        else $error("boost gate on during over-voltage");
    a_zcd_turn_on: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_enable && !i_ovp && !ovp_d_r && !gate_r && zcd_d_r && !i_zcd |=> gate_r)
        else $error("boost gate missed zero-current turn-on");
endmodule : hbms_boost

// [dv/hbms_partner.sv]
// Power stage seen from the sequencer: bootstrap capacitor and boost inductor.
// Sampled on falling edges; outputs feed the comparator inputs of the sequencer.
`timescale 1ns/10ps
module hbms_partner #(
    parameter int unsigned CHARGE_CYCLES = 3
) (
    // Clock
    input  wire logic i_sys_clk,
    // Stage state
    input  wire logic i_supply_on,
    input  wire logic i_bootstrap_on,
    input  wire logic i_boost_gate,
    input  wire logic i_zcd_mute,
    // Comparator decisions
    output logic      o_high_side_ok,
    output logic      o_zcd
);
    int   charge;
    int   zcd_cnt;
    logic boot_d;
    initial begin
        charge = 0;
        zcd_cnt = 0;
        boot_d = 1'b0;
        o_high_side_ok = 1'b0;
        o_zcd = 1'b0;
    end
    always @(negedge i_sys_clk) begin
        boot_d <= i_bootstrap_on;
        // Floating supply gains charge once per low-side on-time
        if (!i_supply_on) charge <= 0;
        else if (i_bootstrap_on && !boot_d && charge < CHARGE_CYCLES) charge <= charge + 1;
        o_high_side_ok <= (charge >= CHARGE_CYCLES);
        // Inductor discharge: detect rises after gate off, falls at zero current
        if (i_boost_gate || i_zcd_mute) zcd_cnt <= 0;
        else zcd_cnt <= zcd_cnt + 1;
        o_zcd <= !i_zcd_mute && !i_boost_gate && zcd_cnt >= 20 && zcd_cnt < 60;
    end
endmodule : hbms_partner

// [dv/half_bridge_mode_sequencer_bench.sv]
// Self-checking bench of the half-bridge mode sequencer.
// Inputs change on falling edges; the partner models bootstrap and boost inductor.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module half_bridge_mode_sequencer_bench;
    import hbms_pkg::*;
    localparam int FEV = 5;
    localparam int WD = 300;
    localparam int ON = 200;
    localparam int DEAD = 64;
    localparam int HALF = 449;
    logic       clk, nrst, supply, dim_hi, dim_lo, boc, bsense, ovp, mute, hs_ok, zcd;
    logic       lo, ho, pg, boot, comp, osc, flt;
    logic       ho_early, boot_bad, overlap, ovp_chk, ovp_bad;
    int         mismatches, comparisons, n;
    // Rows: supply, dim above, dim below | osc run, comp discharge, fault
    logic [5:0] rows [7] = '{6'h02, 6'h22, 6'h2C, 6'h30, 6'h20, 6'h2C, 6'h02};
    hbms_top #(.FAULT_EVTS(FEV), .WDOG_CYC(WD)) dut (
        .i_sys_clk(clk), .i_nrst(nrst), .i_supply_above_start(supply),
        .i_high_side_above_start(hs_ok), .i_dim_above_high(dim_hi), .i_dim_below_low(dim_lo),
        .i_bridge_overcurrent(boc), .i_zero_current_detect(zcd), .i_boost_current_sense(bsense),
        .i_bus_overvoltage(ovp), .o_low_side_drive(lo), .o_high_side_drive(ho),
        .o_boost_gate_drive(pg), .o_bootstrap_on(boot), .o_comp_discharge(comp),
        .o_osc_run(osc), .o_fault(flt));
    hbms_partner #(.CHARGE_CYCLES(3)) partner (
        .i_sys_clk(clk), .i_supply_on(supply), .i_bootstrap_on(boot), .i_boost_gate(pg),
        .i_zcd_mute(mute), .o_high_side_ok(hs_ok), .o_zcd(zcd));
    always #12.5 clk = ~clk;
    always @(negedge clk) begin
        if (ho && !hs_ok) ho_early <= 1'b1;
        if (boot !== lo) boot_bad <= 1'b1;
        if (lo && ho) overlap <= 1'b1;
        if (ovp_chk && pg) ovp_bad <= 1'b1;
    end
    function automatic logic sig(int s);
        return (s == 0) ? lo : (s == 1) ? ho : pg;
    endfunction : sig
    task automatic cyc(int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    task automatic wait_sig(int s, logic v, int lim);
        for (int k = 0; k < lim && sig(s) !== v; k++) @(negedge clk);
    endtask : wait_sig
    task automatic span(int s, logic v, output int k);
        for (k = 0; k < 5000 && sig(s) === v; k++) @(negedge clk);
    endtask : span
    // One switching period: over-current during low-side and during high-side on-time
    task automatic period(logic a, logic b);
        wait_sig(0, 1'b1, 2000);
        boc = a;
        wait_sig(0, 1'b0, 1000);
        boc = 1'b0;
        wait_sig(1, 1'b1, 200);
        boc = b;
        wait_sig(1, 1'b0, 1000);
        boc = 1'b0;
    endtask : period
    task automatic results;
        $display("Counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    initial begin
        #1000000;
        mismatches++;
        results();
    end
    initial begin
        {clk, nrst, supply, dim_hi, dim_lo, boc, bsense, ovp, mute} = '0;
        {ho_early, boot_bad, overlap, ovp_chk, ovp_bad} = '0;
        mismatches = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        foreach (rows[i]) begin
            {supply, dim_hi, dim_lo} = rows[i][5:3];
            cyc(8);
            `CHK({osc, comp, flt}, rows[i][2:0])
            if (!rows[i][2]) `CHK({lo, ho, pg}, 3'h0)
        end
        // Start-up latency and bridge timing
        supply = 1'b1;
        dim_lo = 1'b1;
        n = 0;
        while (lo !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        `CHK(n, 4)
        `CHK(osc, 1'b1)
        span(0, 1'b1, n);
        `CHK(n, HALF - DEAD)
        wait_sig(1, 1'b1, 5000);
        span(1, 1'b1, n);
        `CHK(n, HALF - DEAD)
        span(0, 1'b0, n);
        `CHK(n, DEAD)
        span(0, 1'b1, n);
        `CHK(n, HALF - DEAD)
        span(1, 1'b0, n);
        `CHK(n, DEAD)
        `CHK({ho_early, boot_bad, overlap}, 3'h0)
        // Fault counting, then latch until supply loss
        repeat (3) period(1'b0, 1'b1);
        repeat (FEV - 1) period(1'b1, 1'b0);
        period(1'b0, 1'b0);
        period(1'b1, 1'b0);
        `CHK(flt, 1'b0)
        period(1'b1, 1'b0);
        `CHK(flt, 1'b1)
        `CHK({lo, ho, pg, comp}, 4'h1)
        dim_hi = 1'b1;
        dim_lo = 1'b0;
        cyc(10);
        dim_hi = 1'b0;
        dim_lo = 1'b1;
        cyc(10);
        `CHK({flt, osc}, 2'h2)
        supply = 1'b0;
        cyc(6);
        `CHK({flt, comp}, 2'h1)
        supply = 1'b1;
        cyc(10);
        `CHK(osc, 1'b1)
        // Boost stage: zero-current turn-on, watchdog, over-current, over-voltage
        wait_sig(2, 1'b1, 2000);
        span(2, 1'b1, n);
        `CHK(n, ON)
        span(2, 1'b0, n);
        `CHK(n > 60 && n < 70, 1'b1)
        mute = 1'b1;
        span(2, 1'b1, n);
        span(2, 1'b0, n);
        `CHK(n >= WD - 10 && n <= WD + 10, 1'b1)
        mute = 1'b0;
        cyc(10);
        bsense = 1'b1;
        cyc(4);
        `CHK(pg, 1'b0)
        bsense = 1'b0;
        span(2, 1'b0, n);
        `CHK(n > 55 && n < 70, 1'b1)
        ovp = 1'b1;
        cyc(4);
        `CHK(pg, 1'b0)
        ovp_chk = 1'b1;
        cyc(WD + 100);
        ovp_chk = 1'b0;
        ovp = 1'b0;
        n = 0;
        while (pg !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        `CHK({ovp_bad, n <= 5}, 2'h1)
        // Mid-run reset: all outputs drop at once, then lockout until the synchronisers refill
        nrst = 1'b0;
        cyc(1);
        `CHK({lo, ho, pg, boot, comp, osc, flt}, 7'h00)
        nrst = 1'b1;
        cyc(1);
        `CHK({comp, osc}, 2'h2)
        cyc(3);
        `CHK({comp, osc}, 2'h1)
        results();
    end
endmodule : half_bridge_mode_sequencer_bench
